// ===== crf_pkg.sv
// package: constants and types of the cpu register file and status block
package crf_pkg;
  localparam int NUM_REGS = 32;
  localparam int REG_AW = 5;
  localparam int DATA_AW = 16;
  // data space map
  localparam logic [15:0] REGFILE_LAST = 16'h001f;
  localparam logic [15:0] IO_FIRST = 16'h0020;
  localparam logic [15:0] IO_LAST = 16'h005f;
  localparam logic [15:0] EXT_FIRST = 16'h0060;
  localparam logic [15:0] EXT_LAST = 16'h01ff;
  localparam logic [5:0] STATUS_FLAGS_OFFSET = 6'h3f;
  localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
  // pointer register indices (low byte)
  localparam logic [4:0] PTR_FIRST_LO = 5'h1a;
  localparam logic [4:0] PTR_SECOND_LO = 5'h1c;
  localparam logic [4:0] PTR_THIRD_LO = 5'h1e;
  // status bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // write-back schemes of the register file
  typedef enum logic [1:0] {
    crf_wb_none_t_e,
    crf_wb_byte,
    crf_wb_word
  } crf_wb_t;
  // pointer address modes
  typedef enum logic [1:0] {
    crf_pm_plain,
    crf_pm_disp,
    crf_pm_postinc,
    crf_pm_predec
  } crf_pmode_t;
  // alu operations
  typedef enum logic [3:0] {
    crf_op_add,
    crf_op_adc,
    crf_op_sub,
    crf_op_sbc,
    crf_op_and,
    crf_op_or,
    crf_op_xor,
    crf_op_mov,
    crf_op_inc,
    crf_op_dec,
    crf_op_adiw,
    crf_op_sbiw,
    crf_op_mul
  } crf_op_t;
  // data space regions
  typedef enum logic [1:0] {
    crf_rg_regs,
    crf_rg_io,
    crf_rg_ext,
    crf_rg_sram
  } crf_region_t;
endpackage

// ===== crf_alu.sv
// module: single-cycle alu with flag computation
`timescale 1ns/10ps
module crf_alu (
  // operation
  input wire crf_pkg::crf_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [15:0] w,
  input wire logic [5:0] k,
  input wire logic carry_in,
  // result
  output logic [15:0] result,
  output logic wide,
  output logic [5:0] flags
);
  import crf_pkg::*;
  logic [8:0] s9;
  logic [16:0] s17;
  logic h;
  logic v;
  logic c;
  logic n;
  logic z;

  always_comb begin
    s9 = 9'h000;
    s17 = 17'h00000;
    h = 1'b0;
    v = 1'b0;
    c = 1'b0;
    result = 16'h0000;
    wide = 1'b0;
    case (op)
      crf_op_add, crf_op_adc: begin
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, op == crf_op_adc && carry_in};
        result = {8'h00, s9[7:0]};
        c = s9[8];
        h = (a[3] & b[3]) | (b[3] & ~s9[3]) | (~s9[3] & a[3]);
        v = (a[7] & b[7] & ~s9[7]) | (~a[7] & ~b[7] & s9[7]);
      end
      crf_op_sub, crf_op_sbc: begin
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, op == crf_op_sbc && carry_in};
        result = {8'h00, s9[7:0]};
        c = s9[8];
        h = (~a[3] & b[3]) | (b[3] & s9[3]) | (s9[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~s9[7]) | (~a[7] & b[7] & s9[7]);
      end
      crf_op_and: result = {8'h00, a & b};
      crf_op_or: result = {8'h00, a | b};
      crf_op_xor: result = {8'h00, a ^ b};
      crf_op_mov: result = {8'h00, b};
      crf_op_inc: begin
        result = {8'h00, a + 8'h01};
        v = (a == 8'h7f);
      end
      crf_op_dec: begin
        result = {8'h00, a - 8'h01};
        v = (a == 8'h80);
      end
      crf_op_adiw: begin
        s17 = {1'b0, w} + {11'h000, k};
        result = s17[15:0];
        wide = 1'b1;
        c = ~s17[15] & w[15];
        v = ~w[15] & s17[15];
      end
      crf_op_sbiw: begin
        s17 = {1'b0, w} - {11'h000, k};
        result = s17[15:0];
        wide = 1'b1;
        c = s17[15] & ~w[15];
        v = w[15] & ~s17[15];
      end
      crf_op_mul: begin
        result = {8'h00, a} * {8'h00, b};
        wide = 1'b1;
        c = result[15];
      end
      default: result = 16'h0000;
    endcase
    n = wide ? (op == crf_op_mul ? 1'b0 : result[15]) : result[7];
    z = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
    flags = {h, n ^ v, v, n, z, c};
  end
endmodule // crf_alu

// ===== crf_core.sv
// module: general purpose register file, pointers and status flags
//
// Notes on behaviour
// - thirty-two byte registers, single-cycle access
// - read two operands, write result same cycle
// - six registers form three sixteen-bit pointers
// - registers occupy data addresses zero to 0x1f
// - pairs 26/27, 28/29, 30/31 low/high
// - displacement, post-increment, pre-decrement pointer modes
// - third pointer addresses flash lookup tables
// - byte and word read/write port schemes
// - bit 7 gates all interrupts globally
// - interrupt taken clears, return sets enable
// - bit 6 holds bit store/load copy
// - sign equals negative xor overflow
// - bit 5 half carry from low nibble
// - bit 2 negative result flag
// - bit 1 zero result flag
// - bit 0 carry flag
// - bit 3 signed overflow flag
// - flags update after every alu operation
// - prefetch next instruction while one executes
// - io space directly and at 0x20-0x5f
// - extended io only via load/store
`timescale 1ns/10ps
module crf_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register file read ports
  input wire logic [4:0] rd_a_addr,
  input wire logic [4:0] rd_b_addr,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  output logic [15:0] rd_word_data,
  // alu request
  input wire logic alu_valid,
  input wire crf_pkg::crf_op_t alu_op,
  input wire logic alu_use_imm,
  input wire logic [7:0] alu_imm,
  input wire logic alu_write,
  input wire logic [4:0] alu_dest,
  // direct write port
  input wire crf_pkg::crf_wb_t wr_mode,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // pointer unit
  input wire logic ptr_valid,
  input wire logic [1:0] ptr_sel,
  input wire crf_pkg::crf_pmode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr,
  output logic [15:0] flash_table_addr,
  // data space access to the register file and status flags
  input wire logic ds_valid,
  input wire logic ds_write,
  input wire logic ds_is_io,
  input wire logic [15:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_hit,
  output logic ds_io_sel,
  output logic ds_ext_sel,
  output logic ds_refused,
  // bit copy instructions
  input wire logic bit_store_instr,
  input wire logic bit_load_instr,
  input wire logic [4:0] bit_reg,
  input wire logic [2:0] bit_pos,
  // interrupt control
  input wire logic irq_pending,
  input wire logic irq_taken,
  input wire logic return_from_interrupt,
  input wire logic flag_set,
  input wire logic flag_clr,
  input wire logic [2:0] flag_idx,
  output logic irq_request,
  // fetch pipeline
  input wire logic [15:0] fetch_word,
  input wire logic fetch_stall,
  output logic [15:0] exec_word,
  output logic exec_valid,
  // status
  output logic [7:0] status_flags
);
  import crf_pkg::*;

  localparam logic [4:0] PTR_HIGH_OFS = 5'h01;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] status_flags_reg;
  logic [15:0] exec_word_reg;
  logic exec_valid_reg;
  logic [15:0] ptr_addr_reg;
  logic [7:0] ds_rdata_reg;

  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    case (sel)
      2'h0: ptr_lo = PTR_FIRST_LO;
      2'h1: ptr_lo = PTR_SECOND_LO;
      default: ptr_lo = PTR_THIRD_LO;
    endcase
  endfunction

  function automatic crf_region_t region(input logic [15:0] a);
    if (a <= REGFILE_LAST) region = crf_rg_regs;
    else if (a <= IO_LAST) region = crf_rg_io;
    else if (a <= EXT_LAST) region = crf_rg_ext;
    else region = crf_rg_sram;
  endfunction

  // ----------------------------------------
  // read ports and operands
  // ----------------------------------------
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [15:0] op_w;
  logic [4:0] plo;
  logic [15:0] pval;

  assign op_a = regs_reg[rd_a_addr];
  assign op_b = alu_use_imm ? alu_imm : regs_reg[rd_b_addr];
  assign op_w = {regs_reg[rd_a_addr + PTR_HIGH_OFS], regs_reg[rd_a_addr]};
  assign rd_a_data = op_a;
  assign rd_b_data = regs_reg[rd_b_addr];
  assign rd_word_data = op_w;
  assign plo = ptr_lo(ptr_sel);
  assign pval = {regs_reg[plo + PTR_HIGH_OFS], regs_reg[plo]};
  assign flash_table_addr = {regs_reg[PTR_THIRD_LO + PTR_HIGH_OFS], regs_reg[PTR_THIRD_LO]};

  // ----------------------------------------
  // alu
  // ----------------------------------------
  logic [15:0] alu_result;
  logic alu_wide;
  logic [5:0] alu_flags;

  crf_alu u_alu (
    .op(alu_op),
    .a(op_a),
    .b(op_b),
    .w(op_w),
    .k(alu_imm[5:0]),
    .carry_in(status_flags_reg[FLAG_C]),
    .result(alu_result),
    .wide(alu_wide),
    .flags(alu_flags)
  );

  // ----------------------------------------
  // pointer unit
  // ----------------------------------------
  logic [15:0] ptr_new;
  logic ptr_wb;

  always_comb begin
    ptr_new = pval;
    ptr_wb = 1'b0;
    ptr_addr = pval;
    case (ptr_mode)
      crf_pm_disp: ptr_addr = pval + {10'h000, ptr_disp};
      crf_pm_postinc: begin
        ptr_new = pval + 16'h0001;
        ptr_wb = 1'b1;
      end
      crf_pm_predec: begin
        ptr_new = pval - 16'h0001;
        ptr_addr = ptr_new;
        ptr_wb = 1'b1;
      end
      default: ptr_addr = pval;
    endcase
  end

  // ----------------------------------------
  // data space decode
  // ----------------------------------------
  logic [15:0] ds_full;
  crf_region_t ds_region;
  logic ds_to_status;

  // direct io maps above register file
  assign ds_full = ds_is_io ? (ds_addr & 16'h003f) + IO_FIRST : ds_addr;
  assign ds_region = region(ds_full);
  // status sits at its io offset and also at its data address 0x5f
  assign ds_to_status = ds_region == crf_rg_io && (ds_full - IO_FIRST) == {10'h000, STATUS_FLAGS_OFFSET};
  // extended io refused for direct io
  assign ds_refused = ds_valid && ds_is_io && ds_addr > {10'h000, STATUS_FLAGS_OFFSET};
  assign ds_hit = ds_valid && !ds_refused && (ds_region == crf_rg_regs || ds_to_status);
  assign ds_io_sel = ds_valid && !ds_refused && ds_region == crf_rg_io && !ds_to_status;
  assign ds_ext_sel = ds_valid && !ds_is_io && ds_region == crf_rg_ext;

  // ----------------------------------------
  // register file writes
  // ----------------------------------------
  logic bit_val;
  assign bit_val = regs_reg[bit_reg][bit_pos];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) regs_reg[i] <= 8'h00;
    end else begin
      if (wr_mode == crf_wb_byte) regs_reg[wr_addr] <= wr_data[7:0];
      if (wr_mode == crf_wb_word) begin
        regs_reg[wr_addr] <= wr_data[7:0];
        regs_reg[wr_addr + PTR_HIGH_OFS] <= wr_data[15:8];
      end
      if (alu_valid && alu_write) begin
        regs_reg[alu_dest] <= alu_result[7:0];
        if (alu_wide) regs_reg[alu_dest + PTR_HIGH_OFS] <= alu_result[15:8];
      end
      if (ds_hit && ds_write && ds_region == crf_rg_regs)
        regs_reg[ds_full[4:0]] <= ds_wdata;
      if (ptr_valid && ptr_wb) begin
        regs_reg[plo] <= ptr_new[7:0];
        regs_reg[plo + PTR_HIGH_OFS] <= ptr_new[15:8];
      end
      if (bit_load_instr) regs_reg[bit_reg][bit_pos] <= status_flags_reg[FLAG_T];
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic [7:0] status_flags_next;

  always_comb begin
    status_flags_next = status_flags_reg;
    if (ds_hit && ds_write && ds_to_status) status_flags_next = ds_wdata;
    if (flag_set) status_flags_next[flag_idx] = 1'b1;
    if (flag_clr) status_flags_next[flag_idx] = 1'b0;
    if (alu_valid) begin
      status_flags_next[FLAG_C] = alu_flags[0];
      status_flags_next[FLAG_Z] = alu_flags[1];
      status_flags_next[FLAG_N] = alu_flags[2];
      status_flags_next[FLAG_V] = alu_flags[3];
      status_flags_next[FLAG_S] = alu_flags[2] ^ alu_flags[3];
      status_flags_next[FLAG_H] = alu_flags[5];
    end
    if (bit_store_instr) status_flags_next[FLAG_T] = bit_val;
    if (return_from_interrupt) status_flags_next[FLAG_I] = 1'b1;
    if (irq_taken) status_flags_next[FLAG_I] = 1'b0;
  end

  // flags are not saved on interrupt entry
  always_ff @(posedge clock) begin
    if (rst) status_flags_reg <= STATUS_FLAGS_RESET;
    else status_flags_reg <= status_flags_next;
  end

  assign status_flags = status_flags_reg;
  assign irq_request = irq_pending && status_flags_reg[FLAG_I];

  // ----------------------------------------
  // data space read data and pointer address
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) ds_rdata_reg <= 8'h00;
    else if (ds_hit && !ds_write)
      ds_rdata_reg <= ds_to_status ? status_flags_reg : regs_reg[ds_full[4:0]];
  end
  assign ds_rdata = ds_rdata_reg;

  always_ff @(posedge clock) begin
    if (rst) ptr_addr_reg <= 16'h0000;
    else if (ptr_valid) ptr_addr_reg <= ptr_addr;
  end

  // ----------------------------------------
  // fetch pipeline
  // ----------------------------------------
  // one-stage prefetch register
  always_ff @(posedge clock) begin
    if (rst) begin
      exec_word_reg <= 16'h0000;
      exec_valid_reg <= 1'b0;
    end else if (!fetch_stall) begin
      exec_word_reg <= fetch_word;
      exec_valid_reg <= 1'b1;
    end
  end
  assign exec_word = exec_word_reg;
  assign exec_valid = exec_valid_reg;
endmodule // crf_core

// ===== crf_core_monitor.sv
// checker: port assertions for the register file, pointers and status flags
`timescale 1ns/10ps
module crf_core_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // requests
  input wire logic [4:0] rd_a_addr,
  input wire logic ds_valid,
  input wire logic ds_is_io,
  input wire logic [15:0] ds_addr,
  input wire logic alu_valid,
  input wire logic bit_store_instr,
  input wire logic [4:0] bit_reg,
  input wire logic [2:0] bit_pos,
  input wire logic irq_pending,
  input wire logic irq_taken,
  input wire logic return_from_interrupt,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_stall,
  // answers
  input wire logic [7:0] rd_a_data,
  input wire logic [15:0] rd_word_data,
  input wire logic [15:0] flash_table_addr,
  input wire logic ds_refused,
  input wire logic irq_request,
  input wire logic [15:0] exec_word,
  input wire logic exec_valid,
  input wire logic [7:0] status_flags
);
  logic t_src;
  assign t_src = rd_a_data[bit_pos];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence fetch_taken; !rst && !fetch_stall; endsequence
  sequence exec_shows; exec_valid && exec_word == $past(fetch_word); endsequence
  sequence store_req; bit_store_instr && rd_a_addr == bit_reg; endsequence
  pipe_step_a: assert property (fetch_taken |=> exec_shows)
    else $error("exec word does not follow fetch");
  sign_bit_a: assert property (alu_valid |=> status_flags[4] == (status_flags[3] ^ status_flags[2]))
    else $error("sign flag differs from negative xor overflow");
  irq_gate_a: assert property (irq_request == (irq_pending && status_flags[7]))
    else $error("interrupt request not gated by global enable");
  irq_clear_a: assert property (irq_taken |=> !status_flags[7])
    else $error("global enable kept after interrupt taken");
  return_from_interrupt_set_a: assert property (return_from_interrupt && !irq_taken |=> status_flags[7])
    else $error("global enable not set by return");
  bit_copy_a: assert property (store_req |=> status_flags[6] == $past(t_src))
    else $error("copy bit not stored");
  word_low_a: assert property (rd_word_data[7:0] == rd_a_data)
    else $error("word read low byte differs from byte read");
  flash_ptr_a: assert property (rd_a_addr == 5'h1e |-> rd_word_data == flash_table_addr)
    else $error("table pointer differs from third pointer");
  io_refuse_a: assert property (ds_valid && ds_is_io && ds_addr > 16'h003f |-> ds_refused)
    else $error("direct io beyond range not refused");
endmodule // crf_core_monitor

bind crf_core crf_core_monitor mon (.clock, .rst, .rd_a_addr, .ds_valid, .ds_is_io, .ds_addr,
  .alu_valid, .bit_store_instr, .bit_reg, .bit_pos, .irq_pending, .irq_taken,
  .return_from_interrupt, .fetch_word, .fetch_stall, .rd_a_data, .rd_word_data,
  .flash_table_addr, .ds_refused, .irq_request, .exec_word, .exec_valid, .status_flags);

// ===== crf_exec_model.sv
// partner model: execution side issuing alu work and instruction words
`timescale 1ns/10ps
module crf_exec_model (
  // clock
  input wire logic clock,
  // alu request
  output logic alu_valid,
  output crf_pkg::crf_op_t alu_op,
  output logic alu_use_imm,
  output logic [7:0] alu_imm,
  output logic alu_write,
  output logic [4:0] alu_dest,
  // instruction fetch
  output logic [15:0] fetch_word,
  output logic fetch_stall
);
  import crf_pkg::*;
  initial begin
    {alu_valid, alu_use_imm, alu_write, fetch_stall} = 4'h0;
    alu_op = crf_op_add;
    alu_imm = 8'h00;
    alu_dest = 5'h00;
    fetch_word = 16'h0000;
  end
  // a fresh word each cycle unless the fetch is held
  always @(posedge clock) begin
    if (!fetch_stall) begin
      fetch_word <= fetch_word + 16'h1357;
    end
  end
  // gap idle cycles make a slow issuer
  task exec(input crf_op_t op, input logic [7:0] imm, input logic [4:0] dest, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    {alu_valid, alu_use_imm, alu_write} <= 3'h7;
    alu_op <= op;
    alu_imm <= imm;
    alu_dest <= dest;
    @(posedge clock);
    {alu_valid, alu_write} <= 2'h0;
    // a dropped operand does not keep its value
    alu_imm <= ~imm;
  endtask
  task stall(input int n);
    @(posedge clock);
    fetch_stall <= 1'b1;
    repeat (n) @(posedge clock);
    fetch_stall <= 1'b0;
  endtask
endmodule // crf_exec_model

// ===== cpu_register_file_status_test.sv
// testbench: register file, pointers, data space map and status flags
`timescale 1ns/10ps
module cpu_register_file_status_test;
  import crf_pkg::*;
  typedef struct packed {crf_op_t op; logic [7:0] a, b, r, f;} crf_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] rd_a_addr = 5'h01, rd_b_addr = 5'h00, wr_addr = 5'h00, bit_reg = 5'h00, alu_dest;
  logic [7:0] rd_a_data, rd_b_data, ds_wdata = 8'h00, ds_rdata, status_flags, alu_imm;
  logic [15:0] rd_word_data, wr_data = 16'h0000, ptr_addr, flash_table_addr, w;
  logic [15:0] ds_addr = 16'h0000, fetch_word, exec_word;
  logic [5:0] ptr_disp = 6'h00;
  logic [2:0] bit_pos = 3'h0, flag_idx = 3'h7;
  logic [3:0] sel;
  logic [1:0] ptr_sel = 2'h0;
  logic alu_valid, alu_use_imm, alu_write, fetch_stall, exec_valid, irq_request;
  logic ptr_valid = 1'b0, ds_valid = 1'b0, ds_write = 1'b0, ds_is_io = 1'b0;
  logic ds_hit, ds_io_sel, ds_ext_sel, ds_refused;
  logic bit_store_instr = 1'b0, bit_load_instr = 1'b0, irq_pending = 1'b0, irq_taken = 1'b0;
  logic return_from_interrupt = 1'b0, flag_set = 1'b0, flag_clr = 1'b0;
  crf_op_t alu_op;
  crf_wb_t wr_mode = crf_wb_none_t_e;
  crf_pmode_t ptr_mode = crf_pm_plain;
  int mismatches = 0;
  int num_checks = 0;
  crf_row_t rows [6] = '{'{crf_op_add, 8'h7f, 8'h01, 8'h80, 8'h2c},
    '{crf_op_add, 8'hff, 8'h01, 8'h00, 8'h23}, '{crf_op_sub, 8'h01, 8'h02, 8'hff, 8'h35},
    '{crf_op_and, 8'hf0, 8'h0f, 8'h00, 8'h02}, '{crf_op_xor, 8'h80, 8'h00, 8'h80, 8'h14},
    '{crf_op_inc, 8'h7f, 8'h00, 8'h80, 8'h0c}};
  crf_exec_model cpu (.clock, .alu_valid, .alu_op, .alu_use_imm, .alu_imm, .alu_write,
    .alu_dest, .fetch_word, .fetch_stall);
  crf_core uut (.clock, .rst, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .rd_word_data,
    .alu_valid, .alu_op, .alu_use_imm, .alu_imm, .alu_write, .alu_dest, .wr_mode, .wr_addr,
    .wr_data, .ptr_valid, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .flash_table_addr,
    .ds_valid, .ds_write, .ds_is_io, .ds_addr, .ds_wdata, .ds_rdata, .ds_hit, .ds_io_sel,
    .ds_ext_sel, .ds_refused, .bit_store_instr, .bit_load_instr, .bit_reg, .bit_pos,
    .irq_pending, .irq_taken, .return_from_interrupt, .flag_set, .flag_clr, .flag_idx,
    .irq_request, .fetch_word, .fetch_stall, .exec_word, .exec_valid, .status_flags);
  always #20 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task rdchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd_b_addr <= a;
    #1 chk(rd_b_data, exp);
  endtask
  task wr(input crf_wb_t m, input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_mode <= m;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_mode <= crf_wb_none_t_e;
    wr_data <= ~d;
  endtask
  task ptr(input logic [1:0] s, input crf_pmode_t m, input logic [5:0] d);
    @(posedge clock);
    ptr_valid <= 1'b1;
    ptr_sel <= s;
    ptr_mode <= m;
    ptr_disp <= d;
    #1 w = ptr_addr;
    @(posedge clock);
    ptr_valid <= 1'b0;
  endtask
  task ds(input logic wt, input logic io, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    {ds_valid, ds_write, ds_is_io} <= {1'b1, wt, io};
    ds_addr <= a;
    ds_wdata <= d;
    #1 sel = {ds_hit, ds_io_sel, ds_ext_sel, ds_refused};
    @(posedge clock);
    {ds_valid, ds_write} <= 2'h0;
    ds_addr <= ~a;
    #1;
  endtask
  // whole sequence needs some 100 cycles
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1 chk(status_flags, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(crf_wb_byte, 5'h01, {8'h00, rows[i].a});
      cpu.exec(rows[i].op, rows[i].b, 5'h03, i % 2);
      rdchk(5'h03, rows[i].r);
      chk(status_flags, rows[i].f);
    end
    wr(crf_wb_word, 5'h1a, 16'h1234);
    wr(crf_wb_word, 5'h1c, 16'h0100);
    wr(crf_wb_word, 5'h1e, 16'h2000);
    @(posedge clock);
    rd_a_addr <= 5'h1a;
    #1 chk(rd_word_data, 16'h1234);
    chk(rd_a_data, 8'h34);
    ptr(2'h0, crf_pm_postinc, 6'h00);
    chk(w, 16'h1234);
    rdchk(5'h1a, 8'h35);
    ptr(2'h1, crf_pm_predec, 6'h00);
    chk(w, 16'h00ff);
    rdchk(5'h1d, 8'h00);
    @(posedge clock);
    rd_a_addr <= 5'h1e;
    ptr(2'h3, crf_pm_disp, 6'h05);
    chk(w, 16'h2005);
    chk(flash_table_addr, 16'h2000);
    ptr(2'h2, crf_pm_plain, 6'h3f);
    chk(w, 16'h2000);
    ds(1'b1, 1'b0, 16'h0005, 8'ha5);
    chk(sel, 4'h8);
    rdchk(5'h05, 8'ha5);
    ds(1'b0, 1'b0, 16'h001a, 8'h00);
    chk(ds_rdata, 8'h35);
    ds(1'b1, 1'b1, 16'h003f, 8'h80);
    chk(status_flags, 8'h80);
    ds(1'b0, 1'b0, 16'h005f, 8'h00);
    chk(ds_rdata, 8'h80);
    chk(sel, 4'h8);
    ds(1'b0, 1'b1, 16'h0010, 8'h00);
    chk(sel, 4'h4);
    ds(1'b0, 1'b1, 16'h0040, 8'h00);
    chk(sel[0], 1'b1);
    ds(1'b0, 1'b0, 16'h0060, 8'h00);
    chk(sel, 3'h2);
    ds(1'b0, 1'b0, 16'h01ff, 8'h00);
    chk(sel, 3'h2);
    @(posedge clock);
    irq_pending <= 1'b1;
    #1 chk(irq_request, 1'b1);
    // taken, return, clear, set in turn
    // flags left to software
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {flag_set, flag_clr, return_from_interrupt, irq_taken} <= 4'h1 << k;
      @(posedge clock);
      {flag_set, flag_clr, return_from_interrupt, irq_taken} <= 4'h0;
      #1 chk(status_flags, {k[0], 7'h00});
      chk(irq_request, k[0]);
    end
    @(posedge clock);
    {rd_a_addr, bit_reg, bit_pos, bit_store_instr} <= {5'h05, 5'h05, 3'h0, 1'b1};
    @(posedge clock);
    {bit_reg, bit_pos, bit_store_instr, bit_load_instr} <= {5'h06, 3'h3, 2'h1};
    @(posedge clock);
    bit_load_instr <= 1'b0;
    #1 chk(status_flags, 8'hc0);
    rdchk(5'h06, 8'h08);
    cpu.stall(2);
    @(posedge clock);
    #1 w = fetch_word;
    @(posedge clock);
    #1 chk(exec_word, w);
    chk(exec_valid, 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1 chk(status_flags, 8'h00);
    chk(exec_valid, 1'b0);
    rdchk(5'h05, 8'h00);
    conclude;
  end
endmodule // cpu_register_file_status_test
